//--- inc/mws_map.svh
// Address map, field layout and timing constants of the memory map and wait-state block.
// Assumes one 100 MHz system clock; all address figures are byte addresses unless named as words.
`ifndef MWS_MAP_SVH
`define MWS_MAP_SVH

`define MWS_ADDR_W         24
`define MWS_WORD_ADDR_W    22
`define MWS_DATA_W         32
`define MWS_ADDR16_MASK    24'h00ffff
`define MWS_BOOT_ADDR      24'h000000
`define MWS_BOUND16        24'h008000
`define MWS_BOUND24        24'h800000
`define MWS_BASE16_P0      24'h000000
`define MWS_BASE16_P1      24'h00e800
`define MWS_BASE16_P2      24'h004000
`define MWS_BASE16_P3      24'h008000
`define MWS_BASE24_P0      24'h000000
`define MWS_BASE24_P1      24'hffe800
`define MWS_BASE24_P2      24'h400000
`define MWS_BASE24_P3      24'h800000
`define MWS_ONCHIP_BYTES   24'h001800
`define MWS_RAM_WORDS      1536
`define MWS_IDX_W          11
`define MWS_WF_EXT         2
`define MWS_WF_CNT_HI      1
`define MWS_WF_CNT_LO      0
`define MWS_EXT_MIN_WAITS  2'h2
`define MWS_SEL_ALL        4'h0
`define MWS_SEL_NONE       4'hf
`define MWS_CLK_NS         10
`define MWS_WAIT_STATE_NS  10
`define MWS_WAIT_STATE_CYC ((`MWS_WAIT_STATE_NS + `MWS_CLK_NS - 1) / `MWS_CLK_NS)

`endif

//--- inc/mws_pkg.sv
// Types shared by the memory map and wait-state block and its lane mapper.
// Assumes mws_map.svh supplies the numeric constants.
package mws_pkg;

   typedef enum logic [1:0] {
      DT_BYTE = 2'h0,
      DT_HALF = 2'h1,
      DT_W24  = 2'h2,
      DT_W32  = 2'h3
   } mws_dtype_t;

   typedef enum logic [1:0] {
      TG_RAM0 = 2'h0,
      TG_RAM1 = 2'h1,
      TG_EXT  = 2'h2,
      TG_RAM2 = 2'h3
   } mws_target_t;

   typedef enum logic [4:0] {
      ST_BOOT = 5'h01,
      ST_IDLE = 5'h02,
      ST_WAIT = 5'h04,
      ST_RDY  = 5'h08,
      ST_LAST = 5'h10
   } mws_state_t;

endpackage

//--- logic/mws_lane_map.sv
// Byte-lane mapper: byte selects, write lane replication and read extraction.
// Assumes purely combinational use by the memory controller.
`timescale 1ns/10ps
`include "mws_map.svh"
module mws_lane_map (
   input  wire logic [1:0]               addrLow,
   input  wire mws_pkg::mws_dtype_t      dtype,
   input  wire logic [`MWS_DATA_W-1:0]   wdataIn,
   input  wire logic [`MWS_DATA_W-1:0]   rdataIn,
   output logic      [3:0]               selN,
   output logic      [`MWS_DATA_W-1:0]   wdataOut,
   output logic      [`MWS_DATA_W-1:0]   rdataOut
);
   import mws_pkg::*;

   logic [7:0]  rByte;
   logic [15:0] rHalf;

   always_comb begin
      rByte = rdataIn[8*addrLow +: 8];
      rHalf = addrLow[1] ? rdataIn[31:16] : rdataIn[15:0];
      case (dtype)
         DT_BYTE: begin
            selN     = ~(4'h1 << addrLow);
            wdataOut = {4{wdataIn[7:0]}};
            rdataOut = {24'h000000, rByte};
         end
         DT_HALF: begin
            selN     = addrLow[1] ? 4'h3 : 4'hc;
            wdataOut = {2{wdataIn[15:0]}};
            rdataOut = {16'h0000, rHalf};
         end
         DT_W24: begin
            selN     = `MWS_SEL_ALL;
            wdataOut = {{8{wdataIn[23]}}, wdataIn[23:0]};
            rdataOut = {{8{rdataIn[23]}}, rdataIn[23:0]};
         end
         default: begin
            selN     = `MWS_SEL_ALL;
            wdataOut = wdataIn;
            rdataOut = rdataIn;
         end
      endcase
   end
endmodule

//--- logic/mws_mem_ctrl.sv
// Memory map decode, on-chip RAM and external wait-state sequencing.
// Assumes a core that issues one request at a time and synchronous external memory.
`timescale 1ns/10ps
`include "mws_map.svh"
module mws_mem_ctrl (
   input  wire logic                        clk_sys,
   input  wire logic                        sys_rst,
   input  wire logic                        space_width_select_pin,
   input  wire logic                        ram_placement_pin_0,
   input  wire logic                        ram_placement_pin_1,
   input  wire logic [2:0]                  low_partition_wait_field,
   input  wire logic [2:0]                  high_partition_wait_field,
   input  wire logic                        reqValid,
   input  wire logic                        reqWrite,
   input  wire logic [`MWS_ADDR_W-1:0]      reqAddr,
   input  wire mws_pkg::mws_dtype_t         reqType,
   input  wire logic [`MWS_DATA_W-1:0]      reqWdata,
   input  wire logic [`MWS_DATA_W-1:0]      extRdata,
   input  wire logic                        sync_ready_ack_n,
   output logic                             reqReady_q,
   output logic                             rspValid_q,
   output logic                             rspBoot_q,
   output logic      [`MWS_DATA_W-1:0]      rspData_q,
   output mws_pkg::mws_target_t             memTarget_q,
   output logic      [2:0]                  modeActive_q,
   output logic      [`MWS_WORD_ADDR_W-1:0] word_address_bus_q,
   output logic      [3:0]                  byte_select_n_q,
   output logic                             extStrobe_q,
   output logic                             extWrite_q,
   output logic                             extPartitionHigh_q,
   output logic      [`MWS_DATA_W-1:0]      extWdata_q
);
   import mws_pkg::*;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic [`MWS_ADDR_W-1:0] effAddr(input logic [`MWS_ADDR_W-1:0] a, input logic [2:0] m);
      effAddr = m[2] ? a : (a & `MWS_ADDR16_MASK);
   endfunction

   function automatic logic [`MWS_ADDR_W-1:0] chipBase(input logic [2:0] m);
      case (m)
         3'h0:    chipBase = `MWS_BASE16_P0;
         3'h1:    chipBase = `MWS_BASE16_P1;
         3'h2:    chipBase = `MWS_BASE16_P2;
         3'h3:    chipBase = `MWS_BASE16_P3;
         3'h4:    chipBase = `MWS_BASE24_P0;
         3'h5:    chipBase = `MWS_BASE24_P1;
         3'h6:    chipBase = `MWS_BASE24_P2;
         default: chipBase = `MWS_BASE24_P3;
      endcase
   endfunction

   logic [2:0]                  mode_d, mode_q;
   mws_state_t                  state_d, state_q;
   logic                        bootPending_d, bootPending_q;
   logic [1:0]                  waitCnt_d, waitCnt_q;
   logic                        heldExtCtl_d, heldExtCtl_q;
   logic                        heldBoot_d, heldBoot_q;
   logic [1:0]                  heldLow_d, heldLow_q;
   mws_dtype_t                  heldType_d, heldType_q;
   logic                        reqReady_d, rspValid_d, rspBoot_d;
   logic [`MWS_DATA_W-1:0]      rspData_d, extWdata_d;
   mws_target_t                 memTarget_d;
   logic [`MWS_WORD_ADDR_W-1:0] wordAddr_d;
   logic [3:0]                  selN_d;
   logic                        extStrobe_d, extWrite_d, extHigh_d;

   logic                        accept;
   logic [`MWS_ADDR_W-1:0]      curAddr, eff, chipOff;
   mws_dtype_t                  curType;
   logic                        curWrite, inChip, highSel;
   mws_target_t                 curTgt;
   logic [`MWS_IDX_W-1:0]       ramIdx;
   logic [2:0]                  waitField;
   logic [1:0]                  laneLow;
   mws_dtype_t                  laneType;
   logic [3:0]                  laneSel;
   logic [`MWS_DATA_W-1:0]      laneWdata, laneRdata, laneRin;
   logic [`MWS_DATA_W-1:0]      ram [0:`MWS_RAM_WORDS-1];

   // Boot fetch overrides the core request so the first access is address zero.
   // boot fetch address
   assign curAddr  = bootPending_q ? `MWS_BOOT_ADDR : reqAddr;
   assign curType  = bootPending_q ? DT_W32 : reqType;
   assign curWrite = bootPending_q ? 1'b0 : reqWrite;
   assign accept   = (state_q == ST_IDLE) && (bootPending_q || (reqValid && reqReady_q));

   assign eff     = effAddr(curAddr, mode_q);
   assign chipOff = eff - chipBase(mode_q);
   assign inChip  = (eff >= chipBase(mode_q)) && (chipOff < `MWS_ONCHIP_BYTES);
   assign ramIdx  = chipOff[`MWS_IDX_W+1:2];
   assign highSel = mode_q[2] ? (eff >= `MWS_BOUND24) : (eff >= `MWS_BOUND16);
   assign waitField = highSel ? high_partition_wait_field : low_partition_wait_field;

   always_comb begin
      if (!inChip) begin
         curTgt = TG_EXT;
      end else begin
         case (chipOff[12:11])
            2'h0:    curTgt = TG_RAM0;
            2'h1:    curTgt = TG_RAM1;
            default: curTgt = TG_RAM2;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Byte lanes
   // ----------------------------------------------------------------
   assign laneLow  = (state_q == ST_IDLE) ? curAddr[1:0] : heldLow_q;
   assign laneType = (state_q == ST_IDLE) ? curType : heldType_q;
   assign laneRin  = (state_q == ST_IDLE) ? ram[ramIdx] : extRdata;

   mws_lane_map u_lane (
      .addrLow  (laneLow),
      .dtype    (laneType),
      .wdataIn  (reqWdata),
      .rdataIn  (laneRin),
      .selN     (laneSel),
      .wdataOut (laneWdata),
      .rdataOut (laneRdata)
   );

   // ----------------------------------------------------------------
   // On-chip static RAM
   // ----------------------------------------------------------------
   // static RAM, no refresh
   always_ff @(posedge clk_sys) begin
      if (accept && inChip && curWrite) begin
         for (int b = 0; b < 4; b++) begin
            if (!laneSel[b]) begin
               ram[ramIdx][8*b +: 8] <= laneWdata[8*b +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   always_comb begin
      mode_d        = mode_q;
      state_d       = state_q;
      bootPending_d = bootPending_q;
      waitCnt_d     = waitCnt_q;
      heldExtCtl_d  = heldExtCtl_q;
      heldBoot_d    = heldBoot_q;
      heldLow_d     = heldLow_q;
      heldType_d    = heldType_q;
      rspValid_d    = 1'b0;
      rspBoot_d     = 1'b0;
      rspData_d     = rspData_q;
      memTarget_d   = memTarget_q;
      wordAddr_d    = word_address_bus_q;
      selN_d        = byte_select_n_q;
      extStrobe_d   = extStrobe_q;
      extWrite_d    = extWrite_q;
      extHigh_d     = extPartitionHigh_q;
      extWdata_d    = extWdata_q;
      case (state_q)
         ST_BOOT: begin
            mode_d        = {space_width_select_pin, ram_placement_pin_1, ram_placement_pin_0};
            bootPending_d = 1'b1;
            state_d       = ST_IDLE;
         end
         ST_IDLE: begin
            if (accept) begin
               bootPending_d = 1'b0;
               memTarget_d   = curTgt;
               heldBoot_d    = bootPending_q;
               heldLow_d     = curAddr[1:0];
               heldType_d    = curType;
               if (curTgt == TG_EXT) begin
                  wordAddr_d   = eff[`MWS_ADDR_W-1:2];
                  selN_d       = laneSel;
                  extStrobe_d  = 1'b1;
                  extWrite_d   = curWrite;
                  extWdata_d   = laneWdata;
                  extHigh_d    = highSel;
                  heldExtCtl_d = waitField[`MWS_WF_EXT];
                  waitCnt_d    = waitField[`MWS_WF_CNT_HI:`MWS_WF_CNT_LO];
                  if (waitField[`MWS_WF_EXT] && (waitCnt_d < `MWS_EXT_MIN_WAITS)) begin
                     waitCnt_d = `MWS_EXT_MIN_WAITS;
                  end
                  state_d = ST_WAIT;
               end else begin
                  rspValid_d = 1'b1;
                  rspBoot_d  = bootPending_q;
                  rspData_d  = laneRdata;
               end
            end
         end
         ST_WAIT: begin
            if (waitCnt_q != 2'h0) begin
               waitCnt_d = waitCnt_q - 2'(`MWS_WAIT_STATE_CYC);
            end else if (heldExtCtl_q) begin
               state_d = ST_RDY;
            end else begin
               state_d     = ST_IDLE;
               extStrobe_d = 1'b0;
               selN_d      = `MWS_SEL_NONE;
               rspValid_d  = 1'b1;
               rspBoot_d   = heldBoot_q;
               rspData_d   = laneRdata;
            end
         end
         ST_RDY: begin
            if (!sync_ready_ack_n) begin
               state_d = ST_LAST;
            end
         end
         ST_LAST: begin
            state_d     = ST_IDLE;
            extStrobe_d = 1'b0;
            selN_d      = `MWS_SEL_NONE;
            rspValid_d  = 1'b1;
            rspBoot_d   = heldBoot_q;
            rspData_d   = laneRdata;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      reqReady_d = (state_d == ST_IDLE) && !bootPending_d;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q             <= 3'h0;
         state_q            <= ST_BOOT;
         bootPending_q      <= 1'b0;
         waitCnt_q          <= 2'h0;
         heldExtCtl_q       <= 1'b0;
         heldBoot_q         <= 1'b0;
         heldLow_q          <= 2'h0;
         heldType_q         <= DT_W32;
         reqReady_q         <= 1'b0;
         rspValid_q         <= 1'b0;
         rspBoot_q          <= 1'b0;
         rspData_q          <= 32'h00000000;
         memTarget_q        <= TG_RAM0;
         word_address_bus_q <= 22'h000000;
         byte_select_n_q    <= `MWS_SEL_NONE;
         extStrobe_q        <= 1'b0;
         extWrite_q         <= 1'b0;
         extPartitionHigh_q <= 1'b0;
         extWdata_q         <= 32'h00000000;
      end else begin
         mode_q             <= mode_d;
         state_q            <= state_d;
         bootPending_q      <= bootPending_d;
         waitCnt_q          <= waitCnt_d;
         heldExtCtl_q       <= heldExtCtl_d;
         heldBoot_q         <= heldBoot_d;
         heldLow_q          <= heldLow_d;
         heldType_q         <= heldType_d;
         reqReady_q         <= reqReady_d;
         rspValid_q         <= rspValid_d;
         rspBoot_q          <= rspBoot_d;
         rspData_q          <= rspData_d;
         memTarget_q        <= memTarget_d;
         word_address_bus_q <= wordAddr_d;
         byte_select_n_q    <= selN_d;
         extStrobe_q        <= extStrobe_d;
         extWrite_q         <= extWrite_d;
         extPartitionHigh_q <= extHigh_d;
         extWdata_q         <= extWdata_d;
      end
   end

   assign modeActive_q = mode_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_ext_static1;
      accept && curTgt == TG_EXT && !waitField[`MWS_WF_EXT] && waitField[1:0] == 2'h1;
   endsequence
   sequence s_static1_done;
      extStrobe_q [*2] ##1 (rspValid_q && !extStrobe_q);
   endsequence

   a_boot_fetch_zero: assert property (state_q == ST_BOOT |=> accept && eff == `MWS_BOOT_ADDR && !curWrite)
      else $error("boot fetch not at address zero");
   a_static_one_wait: assert property (s_ext_static1 |=> s_static1_done)
      else $error("static wait count not honoured");
   a_ready_finishes: assert property (state_q == ST_RDY && !sync_ready_ack_n |=> state_q == ST_LAST ##1 rspValid_q)
      else $error("access did not finish after ready");
   a_wait_for_ready: assert property (state_q == ST_RDY && sync_ready_ack_n |=> state_q == ST_RDY && extStrobe_q)
      else $error("access ended without ready");
   a_ext_min_waits: assert property (accept && curTgt == TG_EXT && waitField[`MWS_WF_EXT] |=> !rspValid_q [*5])
      else $error("external wait shorter than two states");
   a_onchip_fast: assert property (accept && curTgt != TG_EXT |=> rspValid_q && memTarget_q != TG_EXT)
      else $error("on-chip access not single cycle");
   a_word_selects: assert property (accept && curTgt == TG_EXT && curType == DT_W32 |=> byte_select_n_q == `MWS_SEL_ALL)
      else $error("word access selects not all lanes");
   a_partition_pick: assert property (accept && curTgt == TG_EXT |=> extPartitionHigh_q == $past(highSel))
      else $error("wrong external partition");
   a_word_address: assert property (accept && curTgt == TG_EXT |=> word_address_bus_q == $past(eff[`MWS_ADDR_W-1:2]))
      else $error("word address mismatch");
   a_mode_stable: assert property (state_q != ST_BOOT |=> $stable(modeActive_q))
      else $error("memory mode changed after reset");
endmodule

//--- bench/mws_ext_mem.sv
// External memory model that answers the memory controller's external bus.
// Assumes strobe, word address, selects and write data stay steady for a whole access.
`timescale 1ns/10ps
module mws_ext_mem (
   input  wire logic        clk_sys,
   input  wire logic        extStrobe,
   input  wire logic        extWrite,
   input  wire logic [21:0] wordAddr,
   input  wire logic [3:0]  selN,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  rdyDelay,
   output logic      [31:0] rdata,
   output logic             readyN
);
   logic [31:0] mem [logic [21:0]];
   logic [31:0] lastQ;
   int          cnt;
   initial begin
      cnt = 0;
      lastQ = 32'h0;
      readyN = 1'h1;
   end
   always @(posedge clk_sys) begin
      if (extStrobe && extWrite && cnt == 0) begin
         if (!mem.exists(wordAddr)) mem[wordAddr] = 32'h0;
         for (int i = 0; i < 4; i++) if (!selN[i]) mem[wordAddr][8*i +: 8] = wdata[8*i +: 8];
      end
      cnt = extStrobe ? cnt + 1 : 0;
      lastQ <= rdata;
      readyN <= !(extStrobe && cnt > 32'(rdyDelay));
   end
   // Outside an access the data lines toggle every cycle so stale data never matches.
   always @(*) rdata = !extStrobe ? ~lastQ : mem.exists(wordAddr) ? mem[wordAddr] : 32'h0;
endmodule

//--- bench/mws_mem_ctrl_tb_top.sv
// Self-checking bench for the memory map and wait-state block in all eight modes.
// Assumes the external memory model in mws_ext_mem.sv and a 100 MHz clock.
`timescale 1ns/10ps
`include "mws_map.svh"
module mws_mem_ctrl_tb_top;
   import mws_pkg::*;
   logic        clk_sys, sys_rst, pin2, pin1, pin0, reqValid, reqWrite, readyN;
   logic        reqReady, rspValid, rspBoot, extStrobe, extWrite, partHigh;
   logic [2:0]  lowField, highField, modeQ, mode;
   logic [23:0] reqAddr;
   logic [31:0] reqWdata, extRdata, rspData, extWdata;
   logic [21:0] wordAddr;
   logic [3:0]  selN, rdyDelay;
   mws_dtype_t  reqType;
   mws_target_t target;
   int          fail_count, n_checks, cycles, seed;

   mws_mem_ctrl DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .space_width_select_pin(pin2),
      .ram_placement_pin_0(pin0), .ram_placement_pin_1(pin1), .low_partition_wait_field(lowField),
      .high_partition_wait_field(highField), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqType(reqType), .reqWdata(reqWdata), .extRdata(extRdata),
      .sync_ready_ack_n(readyN), .reqReady_q(reqReady), .rspValid_q(rspValid), .rspBoot_q(rspBoot),
      .rspData_q(rspData), .memTarget_q(target), .modeActive_q(modeQ), .word_address_bus_q(wordAddr),
      .byte_select_n_q(selN), .extStrobe_q(extStrobe), .extWrite_q(extWrite),
      .extPartitionHigh_q(partHigh), .extWdata_q(extWdata));
   mws_ext_mem u_mem (.clk_sys(clk_sys), .extStrobe(extStrobe), .extWrite(extWrite), .wordAddr(wordAddr),
      .selN(selN), .wdata(extWdata), .rdyDelay(rdyDelay), .rdata(extRdata), .readyN(readyN));

   // ---------------------------------------------------------------
   // Expectations
   // ---------------------------------------------------------------
   function automatic logic [23:0] eff(input logic [23:0] a);
      return mode[2] ? a : (a & `MWS_ADDR16_MASK);
   endfunction
   function automatic logic [23:0] base();
      case (mode)
         3'h0: return `MWS_BASE16_P0;
         3'h1: return `MWS_BASE16_P1;
         3'h2: return `MWS_BASE16_P2;
         3'h3: return `MWS_BASE16_P3;
         3'h4: return `MWS_BASE24_P0;
         3'h5: return `MWS_BASE24_P1;
         3'h6: return `MWS_BASE24_P2;
         default: return `MWS_BASE24_P3;
      endcase
   endfunction
   function automatic logic [1:0] tgt(input logic [23:0] a);
      logic [23:0] o;
      o = eff(a) - base();
      if (o >= `MWS_ONCHIP_BYTES) return 2'h2;
      return (o[12:11] == 2'h2) ? 2'h3 : o[12:11];
   endfunction
   function automatic logic hi(input logic [23:0] a);
      return eff(a) >= (mode[2] ? `MWS_BOUND24 : `MWS_BOUND16);
   endfunction
   function automatic logic [2:0] fld(input logic [23:0] a);
      return hi(a) ? highField : lowField;
   endfunction
   function automatic int lat(input logic [23:0] a);
      logic [2:0] f;
      f = fld(a);
      if (tgt(a) != 2'h2) return 1;
      if (f[2]) return ((f[1:0] < 2'h2) ? 2 : 32'(f[1:0])) + 4;
      return 32'(f[1:0]) + 2;
   endfunction
   function automatic logic [3:0] selx(input logic [1:0] a, input mws_dtype_t t);
      if (t == DT_BYTE) return ~(4'h1 << a);
      if (t == DT_HALF) return a[1] ? 4'h3 : 4'hc;
      return 4'h0;
   endfunction
   function automatic logic [31:0] rdx(input logic [31:0] d, input mws_dtype_t t);
      if (t == DT_BYTE) return {24'h0, d[7:0]};
      if (t == DT_HALF) return {16'h0, d[15:0]};
      if (t == DT_W24) return {{8{d[23]}}, d[23:0]};
      return d;
   endfunction

   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic access(input logic wr, input logic [23:0] a, input mws_dtype_t t, input logic [31:0] d);
      int          k;
      logic [21:0] wa;
      logic [3:0]  sl;
      logic        ph, ew;
      reqValid <= 1'h1;
      reqWrite <= wr;
      reqAddr <= a;
      reqType <= t;
      reqWdata <= d;
      @(posedge clk_sys);
      while (reqReady !== 1'h1) @(posedge clk_sys);
      reqValid <= 1'h0;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
         if (k == 1) begin
            wa = wordAddr;
            sl = selN;
            ph = partHigh;
            ew = extWrite;
         end
      end while (rspValid !== 1'h1 && k < 40);
      if (rdyDelay != 4'h0 && fld(a) > 3'h3 && tgt(a) == 2'h2) check("slow", 1, 32'(k > lat(a)));
      else check("latency", lat(a), k);
      check("target", tgt(a), target);
      if (tgt(a) == 2'h2) begin
         check("wordaddr", eff(a) >> 2, wa);
         check("selects", selx(a[1:0], t), sl);
         check("partition", hi(a), ph);
         check("extwrite", wr, ew);
      end
      if (!wr) check("rdata", rdx(d, t), rspData);
   endtask

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      logic [23:0] a;
      logic [31:0] r, d;
      mws_dtype_t  t;
      int          k;
      {sys_rst, pin2, pin1, pin0, reqValid, reqWrite, mode} = 9'h100;
      {lowField, highField, reqAddr, reqWdata, rdyDelay} = 66'h0;
      reqType = DT_BYTE;
      seed = 32'ha7cd9e0b;
      for (int m = 0; m < 8; m++) begin
         mode = 3'(m);
         {pin2, pin1, pin0} <= 3'(m);
         sys_rst <= 1'h1;
         repeat (10) @(posedge clk_sys);
         sys_rst <= 1'h0;
         k = 0;
         do begin
            @(posedge clk_sys);
            k++;
         end while (!(rspValid === 1'h1 && rspBoot === 1'h1) && k < 40);
         check("mode", 32'(m), modeQ);
         check("boot", tgt(`MWS_BOOT_ADDR), target);
         check("bootflag", 1, rspBoot);
         for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            lowField <= (i < 8) ? 3'(i) : r[2:0];
            highField <= (i < 8) ? 3'(7 - i) : r[5:3];
            rdyDelay <= r[6] ? 4'h6 : 4'h0;
            t = mws_dtype_t'(r[8:7]);
            a = i[0] ? base() + 24'(r[31:12] % 20'h1800) : 24'($random(seed));
            if (i == 2) a = base() + `MWS_ONCHIP_BYTES - 24'h4;
            if (i == 4) a = base() + `MWS_ONCHIP_BYTES;
            if (i == 6) a = mode[2] ? `MWS_BOUND24 : `MWS_BOUND16;
            if (i == 8) a = (mode[2] ? `MWS_BOUND24 : `MWS_BOUND16) - 24'h4;
            a = (t == DT_BYTE) ? a : (t == DT_HALF) ? {a[23:1], 1'h0} : {a[23:2], 2'h0};
            d = $random(seed);
            access(1'h1, a, t, d);
            access(1'h0, mode[2] ? a : a ^ 24'h5a0000, t, d);
         end
         $display("test mode %0d done", m);
      end
      results();
   end
endmodule
